// file: verilog/hsc_config_regs.sv
`timescale 1ns/1ps
// Operation
// - temp rate picks single or averaged conversion
// - polarity bit sets interrupt pin idle level
// - direction bit flags above or below limit
// - gain bit steers correction to channel
// - angle pair field disables or picks axes
// - one bit selects shared X/Y range
// - separate bit selects Z range
// - limits are 8-bit two's complement values
// - limit one role follows function select
// - limit two role follows function select
// - limit three is Z low or offset
// - function select zero disables all compares
module hsc_config_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regHit,
  // from neighbouring register and conversion engine
  input wire logic [1:0] limitFunctionSelect,
  input wire logic [3:0] axisChannelEnables,
  input wire logic [2:0] averagingCount,
  input wire logic convStart,
  input wire logic convDone,
  input wire logic signed [7:0] sampleValue,
  input wire logic [1:0] sampleAxis,
  input wire logic sampleValid,
  // applied settings
  output logic tempSingle,
  output logic [2:0] tempAvgCount,
  output logic gainTargetChannel,
  output logic angleEnable,
  output logic [1:0] angleFirstAxis,
  output logic [1:0] angleSecondAxis,
  output logic xyRangeHigh,
  output logic zRangeHigh,
  output logic [1:0] activeFunction,
  output logic signed [7:0] rotationReference,
  output logic signed [7:0] rotationBand,
  output logic signed [7:0] rotationOffset,
  output logic convBusy,
  // interrupt pin
  output logic irqPinN
);
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] limitOne;
    logic [7:0] limitTwo;
    logic [7:0] limitThree;
    logic [7:0] appSetup;
    logic [7:0] appOne;
    logic [7:0] appTwo;
    logic [7:0] appThree;
    logic [1:0] appFunc;
    logic [3:0] appChan;
    logic [2:0] appAvg;
    hsc_pkg::hsc_conv_type conv;
    logic event_;
    logic pin;
    logic [7:0] rdata;
    logic hit;
  } hsc_state_type;

  hsc_state_type state_ff;
  hsc_state_type nxt_state;
  logic limitHit;
  logic signed [7:0] selLimit;
  logic cmpEnable;
  logic belowDir;

  // field-mode compare: pick the axis low limit for the sample axis
  always_comb begin
    selLimit = state_ff.appOne;
    cmpEnable = 1'b0;
    if (state_ff.appFunc == hsc_pkg::FUNC_FIELD) begin
      cmpEnable = sampleValid && sampleAxis != 2'h3;
      case (sampleAxis)
        hsc_pkg::AXIS_X: selLimit = state_ff.appOne;
        hsc_pkg::AXIS_Y: selLimit = state_ff.appTwo;
        hsc_pkg::AXIS_Z: selLimit = state_ff.appThree;
        default: selLimit = state_ff.appOne;
      endcase
    end else if (state_ff.appFunc == hsc_pkg::FUNC_MAG) begin
      // magnitude: below low limit or above high limit, per direction
      cmpEnable = sampleValid;
      selLimit = state_ff.appSetup[hsc_pkg::DIR_BIT] ?
                 state_ff.appOne : state_ff.appTwo;
    end
  end

  assign belowDir = state_ff.appSetup[hsc_pkg::DIR_BIT];

  hsc_limit_compare u_cmp (
    .sample(sampleValue),
    .limit(selLimit),
    .below(belowDir),
    .enable(cmpEnable),
    .hit(limitHit)
  );

  // register writes, snapshot at conversion start, pin generation
  always_comb begin
    nxt_state = state_ff;
    nxt_state.hit = 1'b0;
    nxt_state.rdata = 8'h00;
    if (regWrite) begin
      case (regAddr)
        hsc_pkg::SETUP_OFFSET: nxt_state.setup = regWdata;
        hsc_pkg::LIMIT_ONE_OFFSET: nxt_state.limitOne = regWdata;
        hsc_pkg::LIMIT_TWO_OFFSET: nxt_state.limitTwo = regWdata;
        hsc_pkg::LIMIT_THREE_OFFSET: nxt_state.limitThree = regWdata;
        default: nxt_state.setup = state_ff.setup;
      endcase
    end
    if (regRead || regWrite) begin
      nxt_state.hit = 1'b1;
      case (regAddr)
        hsc_pkg::SETUP_OFFSET: nxt_state.rdata = state_ff.setup;
        hsc_pkg::LIMIT_ONE_OFFSET: nxt_state.rdata = state_ff.limitOne;
        hsc_pkg::LIMIT_TWO_OFFSET: nxt_state.rdata = state_ff.limitTwo;
        hsc_pkg::LIMIT_THREE_OFFSET: nxt_state.rdata = state_ff.limitThree;
        default: nxt_state.hit = 1'b0;
      endcase
    end
    // snapshot only between conversions so a running one is untouched
    case (state_ff.conv)
      hsc_pkg::ST_IDLE: begin
        if (convStart) begin
          nxt_state.conv = hsc_pkg::ST_CONV;
          nxt_state.appSetup = state_ff.setup;
          nxt_state.appOne = state_ff.limitOne;
          nxt_state.appTwo = state_ff.limitTwo;
          nxt_state.appThree = state_ff.limitThree;
          nxt_state.appFunc = limitFunctionSelect;
          nxt_state.appChan = axisChannelEnables;
          nxt_state.appAvg = averagingCount;
        end
      end
      hsc_pkg::ST_CONV: begin
        if (convDone) begin
          nxt_state.conv = hsc_pkg::ST_IDLE;
        end
      end
      default: nxt_state.conv = hsc_pkg::ST_IDLE;
    endcase
    // event held until the next conversion starts; none when function off
    if (state_ff.appFunc == hsc_pkg::FUNC_NONE) begin
      nxt_state.event_ = 1'b0;
    end else if (limitHit) begin
      nxt_state.event_ = 1'b1;
    end else if (convStart && state_ff.conv == hsc_pkg::ST_IDLE) begin
      nxt_state.event_ = 1'b0;
    end
    // pin level: xnor of event and polarity bit, idle level is the inverse of the polarity bit
    nxt_state.pin = nxt_state.event_ ~^
                    nxt_state.appSetup[hsc_pkg::IRQ_POL_BIT];
    if (rst) begin
      nxt_state = '0;
      nxt_state.setup = hsc_pkg::SETUP_RESET;
      nxt_state.limitOne = hsc_pkg::LIMIT_RESET;
      nxt_state.limitTwo = hsc_pkg::LIMIT_RESET;
      nxt_state.limitThree = hsc_pkg::LIMIT_RESET;
      nxt_state.appSetup = hsc_pkg::SETUP_RESET;
      nxt_state.conv = hsc_pkg::ST_IDLE;
      nxt_state.pin = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
  end

  // outputs straight from the state flops
  assign regRdata = state_ff.rdata;
  assign regHit = state_ff.hit;
  assign irqPinN = state_ff.pin;
  assign convBusy = state_ff.conv == hsc_pkg::ST_CONV;
  // single temp conversion only when a magnetic channel is on
  assign tempSingle = !state_ff.appSetup[hsc_pkg::TEMP_RATE_BIT] &&
                      state_ff.appChan != 4'h0;
  assign tempAvgCount = state_ff.appSetup[hsc_pkg::TEMP_RATE_BIT] ?
                        state_ff.appAvg : 3'h0;
  assign gainTargetChannel = state_ff.appSetup[hsc_pkg::GAIN_CH_BIT];
  assign xyRangeHigh = state_ff.appSetup[hsc_pkg::XY_RANGE_BIT];
  assign zRangeHigh = state_ff.appSetup[hsc_pkg::Z_RANGE_BIT];
  assign activeFunction = state_ff.appFunc;

  // angle pair decode
  logic [1:0] pair;
  assign pair = state_ff.appSetup[hsc_pkg::ANGLE_HI_BIT:hsc_pkg::ANGLE_LO_BIT];
  assign angleEnable = pair != hsc_pkg::PAIR_OFF;
  assign angleFirstAxis = (pair == hsc_pkg::PAIR_YZ) ?
                          hsc_pkg::AXIS_Y : hsc_pkg::AXIS_X;
  assign angleSecondAxis = (pair == hsc_pkg::PAIR_XY) ? hsc_pkg::AXIS_Y :
                           (pair == hsc_pkg::PAIR_OFF) ? hsc_pkg::AXIS_X :
                           hsc_pkg::AXIS_Z;
  // angle roles of the limit registers
  assign rotationReference = (state_ff.appFunc == hsc_pkg::FUNC_ANGLE) ?
                             state_ff.appOne : 8'sh00;
  assign rotationBand = (state_ff.appFunc == hsc_pkg::FUNC_ANGLE) ?
                        state_ff.appTwo : 8'sh00;
  assign rotationOffset = (state_ff.appFunc == hsc_pkg::FUNC_ANGLE ||
                           state_ff.appFunc == hsc_pkg::FUNC_MAG) ?
                          state_ff.appThree : 8'sh00;

  property p_reset_pin;
    @(posedge clk) rst |=> irqPinN;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("pin not idle");

  property p_func_off;
    @(posedge clk) disable iff (rst)
      activeFunction == hsc_pkg::FUNC_NONE |=> irqPinN ==
      !state_ff.appSetup[hsc_pkg::IRQ_POL_BIT];
  endproperty
  a_func_off: assert property (p_func_off) else $error("compare active");

  property p_hold_busy;
    @(posedge clk) disable iff (rst)
      convBusy && !convDone |=> $stable(state_ff.appSetup);
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("setup changed");

  property p_write_read;
    @(posedge clk) disable iff (rst)
      regWrite && regAddr == hsc_pkg::LIMIT_ONE_OFFSET ##1
      regRead && !regWrite && regAddr == hsc_pkg::LIMIT_ONE_OFFSET
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_write_read: assert property (p_write_read) else $error("bad readback");
  property p_angle_off;
    @(posedge clk) disable iff (rst) $rose(convBusy) |-> angleEnable !=
      ($past(state_ff.setup[hsc_pkg::ANGLE_HI_BIT:hsc_pkg::ANGLE_LO_BIT]) ==
      hsc_pkg::PAIR_OFF);
  endproperty
  a_angle_off: assert property (p_angle_off) else $error("angle on");

  property p_temp;
    @(posedge clk) disable iff (rst)
      state_ff.appSetup[hsc_pkg::TEMP_RATE_BIT] |-> !tempSingle;
  endproperty
  a_temp: assert property (p_temp) else $error("temp mode");

  property p_ranges;
    @(posedge clk) disable iff (rst) $rose(convBusy) |->
      xyRangeHigh == $past(state_ff.setup[hsc_pkg::XY_RANGE_BIT]) &&
      zRangeHigh == $past(state_ff.setup[hsc_pkg::Z_RANGE_BIT]);
  endproperty
  a_ranges: assert property (p_ranges) else $error("range not applied");

  property p_gain;
    @(posedge clk) disable iff (rst) $rose(convBusy) |->
      gainTargetChannel == $past(state_ff.setup[hsc_pkg::GAIN_CH_BIT]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not applied");
endmodule

// file: common/hsc_pkg.sv
package hsc_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] SETUP_OFFSET = 8'h03;
  localparam logic [7:0] LIMIT_ONE_OFFSET = 8'h04;
  localparam logic [7:0] LIMIT_TWO_OFFSET = 8'h05;
  localparam logic [7:0] LIMIT_THREE_OFFSET = 8'h06;
  // reset values
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  // setup field positions
  localparam int TEMP_RATE_BIT = 7;
  localparam int IRQ_POL_BIT = 6;
  localparam int DIR_BIT = 5;
  localparam int GAIN_CH_BIT = 4;
  localparam int ANGLE_HI_BIT = 3;
  localparam int ANGLE_LO_BIT = 2;
  localparam int XY_RANGE_BIT = 1;
  localparam int Z_RANGE_BIT = 0;
  // angle pair codes
  localparam logic [1:0] PAIR_OFF = 2'h0;
  localparam logic [1:0] PAIR_XY = 2'h1;
  localparam logic [1:0] PAIR_YZ = 2'h2;
  localparam logic [1:0] PAIR_XZ = 2'h3;
  // limit function codes
  localparam logic [1:0] FUNC_NONE = 2'h0;
  localparam logic [1:0] FUNC_ANGLE = 2'h1;
  localparam logic [1:0] FUNC_FIELD = 2'h2;
  localparam logic [1:0] FUNC_MAG = 2'h3;
  // axis codes
  localparam logic [1:0] AXIS_X = 2'h0;
  localparam logic [1:0] AXIS_Y = 2'h1;
  localparam logic [1:0] AXIS_Z = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV} hsc_conv_type;
endpackage

// file: verilog/hsc_limit_compare.sv
`timescale 1ns/1ps
module hsc_limit_compare (
  // operands
  input wire logic signed [7:0] sample,
  input wire logic signed [7:0] limit,
  // control
  input wire logic below,
  input wire logic enable,
  // result
  output logic hit
);
  // strict compare; equality never flags, which avoids chatter at the limit
  always_comb begin
    if (!enable) begin
      hit = 1'b0;
    end else if (below) begin
      hit = sample < limit;
    end else begin
      hit = sample > limit;
    end
  end
endmodule

// file: verif/hsc_host_model.sv
`timescale 1ns/1ps
// host side of the register port, one byte per request
module hsc_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regHit
);
  // idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'hff;
    regWdata = 8'h00;
  end
  // released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  // write then read of one place in back-to-back cycles, no idle between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v,
                       output logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = v;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b1;
    regWdata = ~v;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask
  // answer stands only in the cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic h);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdata;
    h = regHit;
  endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] setup;
    logic [1:0] first;
    logic [1:0] second;
  } hsc_row_type;
  // clock, reset and engine inputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] limitFunctionSelect = 2'h0;
  logic convStart = 1'b0;
  logic convDone = 1'b0;
  logic signed [7:0] sampleValue = 8'h00;
  logic [1:0] sampleAxis = 2'h0;
  logic sampleValid = 1'b0;
  logic [3:0] axisChannelEnables = 4'h7;
  logic [2:0] averagingCount = 3'h5;
  // register port and applied settings
  logic regWrite, regRead, regHit, tempSingle, gainTargetChannel;
  logic angleEnable, xyRangeHigh, zRangeHigh, convBusy, irqPinN, h;
  logic [7:0] regAddr, regWdata, regRdata, d;
  logic [2:0] tempAvgCount;
  logic [1:0] angleFirstAxis, angleSecondAxis, activeFunction;
  logic signed [7:0] rotationReference, rotationBand, rotationOffset;
  int errCount = 0;
  int compares = 0;
  // setups with the angle axes they should give
  hsc_row_type rows [4] = '{
    '{8'h84, hsc_pkg::AXIS_X, hsc_pkg::AXIS_Y},
    '{8'h5b, hsc_pkg::AXIS_Y, hsc_pkg::AXIS_Z},
    '{8'h2e, hsc_pkg::AXIS_X, hsc_pkg::AXIS_Z},
    '{8'h11, hsc_pkg::AXIS_X, hsc_pkg::AXIS_X}};
  // channel enables and averaging stand in for the neighbour register
  hsc_config_regs hsc_config_regs_inst (.clk, .rst, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .regHit, .limitFunctionSelect,
    .axisChannelEnables, .averagingCount, .convStart,
    .convDone, .sampleValue, .sampleAxis, .sampleValid, .tempSingle,
    .tempAvgCount, .gainTargetChannel, .angleEnable, .angleFirstAxis,
    .angleSecondAxis, .xyRangeHigh, .zRangeHigh, .activeFunction,
    .rotationReference, .rotationBand, .rotationOffset, .convBusy,
    .irqPinN);
  hsc_host_model hsc_host_model_inst (.clk, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .regHit);
  // clock
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    hsc_host_model_inst.wr(a, v);
  endtask
  // one-cycle engine pulse, start or done; outputs settle before return
  task automatic eng(input logic start);
    @(negedge clk);
    convStart = start;
    convDone = !start;
    @(negedge clk);
    convStart = 1'b0;
    convDone = 1'b0;
    @(negedge clk);
  endtask
  // pin changes on the same edge that latches the event, one edge after the sample, so wait past that
  task automatic smp(input logic [1:0] ax, input logic [7:0] v);
    @(negedge clk);
    sampleAxis = ax;
    sampleValue = v;
    sampleValid = 1'b1;
    @(negedge clk);
    sampleValid = 1'b0;
    sampleValue = ~v;
    repeat (2) @(negedge clk);
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // run is under two hundred cycles; this is far beyond it
  initial begin
    #200000;
    errCount++;
    close_out();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk("irq", 8'h01, irqPinN);
    wr(8'h07, 8'hff);
    // reset values, then the unmapped place
    for (int a = 3; a < 8; a++) begin
      hsc_host_model_inst.rd(8'(a), d, h);
      chk("rdata", 8'h00, d);
      chk("hit", (a < 7) ? 8'h01 : 8'h00, h);
    end
    for (int i = 0; i < 4; i++) begin
      wr(hsc_pkg::SETUP_OFFSET, rows[i].setup);
      hsc_host_model_inst.rd(hsc_pkg::SETUP_OFFSET, d, h);
      chk("setup", rows[i].setup, d);
      eng(1'b1);
      chk("single", !rows[i].setup[7], tempSingle);
      if (rows[i].setup[7]) begin
        chk("avg", 8'h05, tempAvgCount);
      end
      chk("irq", !rows[i].setup[6], irqPinN);
      chk("gain", rows[i].setup[4], gainTargetChannel);
      chk("angle", rows[i].setup[3:2] != 2'h0, angleEnable);
      if (rows[i].setup[3:2] != 2'h0) begin
        chk("first", rows[i].first, angleFirstAxis);
        chk("second", rows[i].second, angleSecondAxis);
      end
      chk("xy", rows[i].setup[1], xyRangeHigh);
      chk("z", rows[i].setup[0], zRangeHigh);
      eng(1'b0);
    end
    // signed limits near the ends of the range
    hsc_host_model_inst.wr_rd(hsc_pkg::LIMIT_ONE_OFFSET, 8'h81, d);
    chk("rdata", 8'h81, d);
    wr(hsc_pkg::LIMIT_TWO_OFFSET, 8'h7f);
    wr(hsc_pkg::LIMIT_THREE_OFFSET, 8'hc0);
    wr(hsc_pkg::SETUP_OFFSET, 8'h00);
    limitFunctionSelect = hsc_pkg::FUNC_ANGLE;
    eng(1'b1);
    chk("func", 8'h01, activeFunction);
    chk("ref", 8'h81, rotationReference);
    chk("band", 8'h7f, rotationBand);
    chk("offs", 8'hc0, rotationOffset);
    // writes and a second start while busy leave the running set alone
    wr(hsc_pkg::SETUP_OFFSET, 8'h03);
    wr(hsc_pkg::LIMIT_ONE_OFFSET, 8'h11);
    eng(1'b1);
    chk("z", 8'h00, zRangeHigh);
    chk("ref", 8'h81, rotationReference);
    eng(1'b0);
    limitFunctionSelect = hsc_pkg::FUNC_FIELD;
    eng(1'b1);
    chk("z", 8'h01, zRangeHigh);
    chk("func", 8'h02, activeFunction);
    smp(hsc_pkg::AXIS_X, 8'h11);
    chk("irq", 8'h01, irqPinN);
    smp(hsc_pkg::AXIS_Y, 8'h7f);
    chk("irq", 8'h01, irqPinN);
    smp(hsc_pkg::AXIS_Z, 8'hc1);
    chk("irq", 8'h00, irqPinN);
    eng(1'b0);
    // active-high pin, below-limit compare
    wr(hsc_pkg::SETUP_OFFSET, 8'h60);
    eng(1'b1);
    chk("irq", 8'h00, irqPinN);
    smp(hsc_pkg::AXIS_X, 8'h11);
    chk("irq", 8'h00, irqPinN);
    smp(hsc_pkg::AXIS_X, 8'h10);
    chk("irq", 8'h01, irqPinN);
    eng(1'b0);
    wr(hsc_pkg::SETUP_OFFSET, 8'h00);
    limitFunctionSelect = hsc_pkg::FUNC_NONE;
    eng(1'b1);
    smp(hsc_pkg::AXIS_X, 8'h7f);
    chk("irq", 8'h01, irqPinN);
    eng(1'b0);
    // magnitude, below limit one
    wr(hsc_pkg::SETUP_OFFSET, 8'h20);
    limitFunctionSelect = hsc_pkg::FUNC_MAG;
    eng(1'b1);
    chk("offs", 8'hc0, rotationOffset);
    smp(hsc_pkg::AXIS_X, 8'h12);
    chk("irq", 8'h01, irqPinN);
    smp(hsc_pkg::AXIS_Y, 8'h10);
    chk("irq", 8'h00, irqPinN);
    eng(1'b0);
    // no magnetic channel: no single temperature conversion
    axisChannelEnables = 4'h0;
    eng(1'b1);
    chk("single", 8'h00, tempSingle);
    eng(1'b0);
    close_out();
  end
endmodule
